// File: src/vpo_voltage_path.sv
// Voltage path output select, filter control and measurement sequencer
// Function
// - Data-ready mask bit 4 gates interrupt, reset 0
// - Two-bit source select, reset picks second comb
// - Bit 7 picks FIR or moving average
// - Four-bit moving average depth, reset bypass
// - Addresses 0x19 to 0x2C ignore writes
// - Lock input blocks writes to test span
// - Timed standby measures each standby period
// - Standby stays idle until the next standby period starts
// - Standby result raises interrupt, then idles until the next standby period
// - Results inside settle time are discarded
// - Standby delivers every third conversion only
// - Init phase toggles interrupt at oscillator rate
// - Start command raises conversion run during stabilization, first period after it
// - First interrupt one period after stabilization
// - Status clears only when host reads it
// - Data registers change only at period end
`timescale 1ns/1ps
`include "vpo_params.svh"
module vpo_voltage_path
  import vpo_pkg::*;
#(
  parameter logic [31:0] INIT_CYC   = 32'(`VPO_INIT_US * (`VPO_CLK_HZ / 1000000)),
  parameter logic [31:0] STAB_CYC   = 32'(`VPO_STAB_US * (`VPO_CLK_HZ / 1000000)),
  parameter logic [31:0] CONV_CYC   = 32'(`VPO_CONV_US * (`VPO_CLK_HZ / 1000000)),
  parameter logic [31:0] SETTLE_CYC = 32'(`VPO_SETTLE_US * (`VPO_CLK_HZ / 1000000)),
  parameter logic [31:0] SBCONV_CYC =
    32'((`VPO_FIRST_US / `VPO_SB_EVERY) * (`VPO_CLK_HZ / 1000000)),
  parameter logic [31:0] STBY_CYC   = 32'(64'(`VPO_STBY_S) * 64'(`VPO_CLK_HZ))
)(
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  // Serial register port
  input  wire logic       sclk_in,
  input  wire logic       spi_cs_n_in,
  input  wire logic       mosi_in,
  output logic            miso_out,
  output logic            miso_oe_out,
  // Measurement chain
  input  vpo_words_s      words_in,
  input  wire logic       test_lock_in,
  output logic            ma_enable_out,
  output logic [3:0]      ma_depth_out,
  output logic            conv_run_out,
  // Interrupt pin
  output logic            int_out
);

  localparam logic [15:0] LP_HALF_CYC = 16'(`VPO_CLK_HZ / (2 * `VPO_LPOSC_HZ));
  localparam logic [1:0]  SB_LAST     = 2'(`VPO_SB_EVERY - 1);

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  function automatic logic in_span(input logic [6:0] a, input logic [6:0] lo,
                                   input logic [6:0] hi);
    in_span = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic write_ok(input logic [6:0] a, input logic lock);
    write_ok = !in_span(a, `VPO_RO_LO, `VPO_RO_HI) &&
               !(lock && in_span(a, `VPO_TEST_LO, `VPO_RO_HI));
  endfunction

  // ----------------------------------------------------------------
  // Link
  // ----------------------------------------------------------------
  vpo_req_s   req;
  logic [7:0] rdata;

  vpo_spi_link u_link (
    .clk_sys_in  (clk_sys_in),
    .reset_in    (reset_in),
    .sclk_in     (sclk_in),
    .spi_cs_n_in (spi_cs_n_in),
    .mosi_in     (mosi_in),
    .miso_out    (miso_out),
    .miso_oe_out (miso_oe_out),
    .rdata_in    (rdata),
    .req_out     (req)
  );

  // ----------------------------------------------------------------
  // Registers and sequencer state
  // ----------------------------------------------------------------
  vpo_state_e  state_q, state_d;
  logic [31:0] tmr_q, tmr_d;
  logic [31:0] stby_q, stby_d;
  logic [15:0] lp_q, lp_d;
  logic        tog_q, tog_d;
  logic [1:0]  nconv_q, nconv_d;
  logic [15:0] data_q, data_d;
  logic        stat_q, stat_d;
  logic [7:0]  dec2_q, dec2_d;
  logic [7:0]  filt_q, filt_d;
  logic        int_q, int_d;
  logic        run_q, run_d;
  logic        cmd_wr, capture, wr_en, stat_rd;
  logic [15:0] sel_word;

  assign wr_en   = req.wr && write_ok(req.addr, test_lock_in);
  assign cmd_wr  = wr_en && (req.addr == `VPO_ADDR_MODE) && (state_q != ST_INIT);
  assign stat_rd = req.rd && (req.addr == `VPO_ADDR_STATUS);

  // Output source select
  always_comb begin
    case (dec2_q[`VPO_SEL_LSB +: 2])
      `VPO_SRC_FILT:   sel_word = filt_q[`VPO_MA_BIT] ? words_in.avg : words_in.fir;
      `VPO_SRC_CIC2:   sel_word = words_in.cic2;
      `VPO_SRC_DECHOP: sel_word = words_in.dechop;
      default:         sel_word = words_in.cic1;
    endcase
  end

  // Register read mux
  always_comb begin
    case (req.addr)
      `VPO_ADDR_STATUS:  rdata = {7'h00, stat_q};
      `VPO_ADDR_STATE:   rdata = {1'b0, state_q};
      `VPO_ADDR_DATA_HI: rdata = data_q[15:8];
      `VPO_ADDR_DATA_LO: rdata = data_q[7:0];
      `VPO_ADDR_DEC2:    rdata = dec2_q;
      `VPO_ADDR_FILT:    rdata = filt_q;
      default:           rdata = 8'h00;
    endcase
  end

  // Next-state logic
  always_comb begin
    state_d = state_q;
    tmr_d   = tmr_q + 32'h1;
    stby_d  = stby_q;
    lp_d    = lp_q;
    tog_d   = tog_q;
    nconv_d = nconv_q;
    data_d  = data_q;
    dec2_d  = dec2_q;
    filt_d  = filt_q;
    capture = 1'b0;
    if (wr_en && req.addr == `VPO_ADDR_DEC2) begin
      dec2_d = req.data & `VPO_DEC2_WMASK;
    end
    if (wr_en && req.addr == `VPO_ADDR_FILT) begin
      filt_d = req.data & `VPO_FILT_WMASK;
    end
    case (state_q)
      ST_INIT: begin
        lp_d = lp_q + 16'h1;
        if (lp_q == LP_HALF_CYC - 16'h1) begin
          lp_d  = 16'h0;
          tog_d = ~tog_q;
        end
        if (tmr_q == INIT_CYC - 32'h1) begin
          state_d = ST_STOP;
          tog_d   = 1'b0;
        end
      end
      ST_STAB: begin
        if (tmr_q == STAB_CYC - 32'h1) begin
          state_d = ST_RUN;
          tmr_d   = 32'h0;
        end
      end
      ST_RUN: begin
        if (tmr_q == CONV_CYC - 32'h1) begin
          capture = 1'b1;
          tmr_d   = 32'h0;
        end
      end
      ST_SB_IDLE: begin
        tmr_d = 32'h0;
      end
      ST_SB_SETTLE: begin
        if (tmr_q == SETTLE_CYC - 32'h1) begin
          state_d = ST_SB_MEAS;
          tmr_d   = 32'h0;
          nconv_d = 2'h0;
        end
      end
      ST_SB_MEAS: begin
        if (tmr_q == SBCONV_CYC - 32'h1) begin
          tmr_d   = 32'h0;
          nconv_d = nconv_q + 2'h1;
          if (nconv_q == SB_LAST) begin
            capture = 1'b1;
            state_d = ST_SB_IDLE;
          end
        end
      end
      default: begin
        tmr_d = 32'h0;
      end
    endcase
    // Standby period runs through the whole standby cycle
    if (state_q == ST_SB_IDLE || state_q == ST_SB_SETTLE || state_q == ST_SB_MEAS) begin
      stby_d = stby_q + 32'h1;
      if (stby_q == STBY_CYC - 32'h1) begin
        stby_d = 32'h0;
        if (state_q == ST_SB_IDLE) begin
          state_d = ST_SB_SETTLE;
          tmr_d   = 32'h0;
        end
      end
    end
    if (cmd_wr) begin
      tmr_d  = 32'h0;
      stby_d = 32'h0;
      case (req.data)
        `VPO_CMD_START: state_d = ST_STAB;
        `VPO_CMD_STOP:  state_d = ST_STOP;
        `VPO_CMD_STBY:  state_d = ST_SB_IDLE;
        default:        state_d = state_q;
      endcase
    end
    if (capture) begin
      data_d = sel_word;
    end
    // Set wins over clear-on-read
    stat_d = capture | (stat_q & ~stat_rd);
    int_d  = (state_d == ST_INIT) ? tog_d : (stat_d & ~dec2_d[`VPO_MASK_BIT]);
    run_d  = (state_d == ST_STAB) || (state_d == ST_RUN) ||
             (state_d == ST_SB_SETTLE) || (state_d == ST_SB_MEAS);
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_q <= ST_INIT;
      tmr_q   <= 32'h0;
      stby_q  <= 32'h0;
      lp_q    <= 16'h0;
      tog_q   <= 1'b0;
      nconv_q <= 2'h0;
      data_q  <= 16'h0;
      stat_q  <= 1'b0;
      dec2_q  <= `VPO_DEC2_RST;
      filt_q  <= `VPO_FILT_RST;
      int_q   <= 1'b0;
      run_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      tmr_q   <= tmr_d;
      stby_q  <= stby_d;
      lp_q    <= lp_d;
      tog_q   <= tog_d;
      nconv_q <= nconv_d;
      data_q  <= data_d;
      stat_q  <= stat_d;
      dec2_q  <= dec2_d;
      filt_q  <= filt_d;
      int_q   <= int_d;
      run_q   <= run_d;
    end
  end

  assign int_out       = int_q;
  assign conv_run_out  = run_q;
  assign ma_enable_out = filt_q[`VPO_MA_BIT];
  assign ma_depth_out  = filt_q[`VPO_DEPTH_LSB +: 4];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  AST_INT_MASKED: assert property (
    (state_q != ST_INIT && dec2_q[`VPO_MASK_BIT]) |-> !int_out)
    else $error("interrupt seen while data-ready is masked");

  AST_SRC_CIC2: assert property (
    (capture && dec2_q[3:2] == `VPO_SRC_CIC2) |=> data_q == $past(words_in.cic2))
    else $error("captured word is not the second comb output");

  AST_SRC_MA: assert property (
    (capture && dec2_q[3:2] == `VPO_SRC_FILT && filt_q[7]) |=> data_q == $past(words_in.avg))
    else $error("moving average not selected as filter output");

  AST_RO_SPAN: assert property (
    (req.wr && req.addr >= `VPO_RO_LO && req.addr <= `VPO_RO_HI) |-> !wr_en)
    else $error("write into read-only span took effect");

  AST_TEST_LOCK: assert property (
    (req.wr && test_lock_in && req.addr >= `VPO_TEST_LO && req.addr <= `VPO_RO_HI) |-> !wr_en)
    else $error("write into locked test span accepted");

  AST_INIT_LEN: assert property (
    (state_q == ST_STOP && $past(state_q) == ST_INIT) |-> $past(tmr_q) == INIT_CYC - 32'h1)
    else $error("init phase length wrong");

  AST_STAB_LEN: assert property (
    (state_q == ST_RUN && $past(state_q) == ST_STAB) |-> $past(tmr_q) == STAB_CYC - 32'h1)
    else $error("stabilization length wrong");

  AST_SETTLE_LEN: assert property (
    (state_q == ST_SB_MEAS && $past(state_q) == ST_SB_SETTLE)
      |-> $past(tmr_q) == SETTLE_CYC - 32'h1 && nconv_q == 2'h0)
    else $error("standby measured before settling ended");

  AST_SB_DONE: assert property (
    (state_q == ST_SB_MEAS && !cmd_wr && tmr_q == SBCONV_CYC - 32'h1 && nconv_q == SB_LAST)
      |=> state_q == ST_SB_IDLE && stat_q)
    else $error("standby result did not flag and stop");

  AST_STAT_HOLD: assert property (
    (stat_q && !stat_rd) |=> stat_q)
    else $error("status cleared without a read");

  AST_DATA_HOLD: assert property (
    !capture |=> $stable(data_q))
    else $error("data register changed outside period end");

  AST_STOP_QUIET: assert property (
    (state_q == ST_STOP && !cmd_wr) |=> state_q == ST_STOP && !conv_run_out)
    else $error("stopped state left without a command");

endmodule

// File: shared/vpo_params.svh
// Constants for the voltage path output and sequencing block
`ifndef VPO_PARAMS_SVH
`define VPO_PARAMS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define VPO_ADDR_MODE    7'h01
`define VPO_ADDR_STATUS  7'h02
`define VPO_ADDR_STATE   7'h03
`define VPO_ADDR_DATA_HI 7'h04
`define VPO_ADDR_DATA_LO 7'h05
`define VPO_ADDR_DEC2    7'h46
`define VPO_ADDR_FILT    7'h47
`define VPO_RO_LO        7'h19
`define VPO_RO_HI        7'h2c
`define VPO_TEST_LO      7'h1a

// ----------------------------------------------------------------
// Field positions, write masks and reset values
// ----------------------------------------------------------------
`define VPO_MASK_BIT     4
`define VPO_SEL_LSB      2
`define VPO_MA_BIT       7
`define VPO_DEPTH_LSB    3
`define VPO_DEC2_WMASK   8'h1c
`define VPO_FILT_WMASK   8'hf8
`define VPO_DEC2_RST     8'h04
`define VPO_FILT_RST     8'h00
`define VPO_SRC_FILT     2'h0
`define VPO_SRC_CIC2     2'h1
`define VPO_SRC_DECHOP   2'h2
`define VPO_SRC_CIC1     2'h3

// ----------------------------------------------------------------
// Mode commands
// ----------------------------------------------------------------
`define VPO_CMD_START    8'h01
`define VPO_CMD_STOP     8'h02
`define VPO_CMD_STBY     8'h03

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define VPO_CLK_HZ       250000000
`define VPO_LPOSC_HZ     262000
`define VPO_INIT_US      500
`define VPO_STAB_US      1500
`define VPO_CONV_US      1000
`define VPO_SETTLE_US    2000
`define VPO_FIRST_US     3000
`define VPO_SB_EVERY     3
`define VPO_STBY_S       10

`endif

// File: shared/vpo_pkg.sv
// Types shared by the voltage path output and sequencing block
package vpo_pkg;

  typedef enum logic [6:0] {
    ST_INIT      = 7'h01,
    ST_STOP      = 7'h02,
    ST_STAB      = 7'h04,
    ST_RUN       = 7'h08,
    ST_SB_IDLE   = 7'h10,
    ST_SB_SETTLE = 7'h20,
    ST_SB_MEAS   = 7'h40
  } vpo_state_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] data;
  } vpo_req_s;

  typedef struct packed {
    logic [15:0] fir;
    logic [15:0] avg;
    logic [15:0] cic2;
    logic [15:0] dechop;
    logic [15:0] cic1;
  } vpo_words_s;

endpackage

// File: src/vpo_spi_link.sv
// Serial register port: samples the link pins and decodes frames
`timescale 1ns/1ps
module vpo_spi_link
  import vpo_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  // Link pins
  input  wire logic       sclk_in,
  input  wire logic       spi_cs_n_in,
  input  wire logic       mosi_in,
  output logic            miso_out,
  output logic            miso_oe_out,
  // Register side
  input  wire logic [7:0] rdata_in,
  output vpo_req_s        req_out
);

  logic [2:0]  sclk_q;
  logic [1:0]  csn_q;
  logic [1:0]  mosi_q;
  logic [4:0]  cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d;
  logic [7:0]  tx_q, tx_d;
  logic        oe_q, oe_d;
  vpo_req_s    req_q, req_d;
  logic        rise, fall;

  assign rise        = sclk_q[1] & ~sclk_q[2];
  assign fall        = ~sclk_q[1] & sclk_q[2];
  assign req_out     = req_q;
  assign miso_out    = tx_q[7];
  assign miso_oe_out = oe_q;

  always_comb begin
    cnt_d     = cnt_q;
    sh_d      = sh_q;
    tx_d      = tx_q;
    oe_d      = oe_q;
    req_d     = req_q;
    req_d.wr  = 1'b0;
    req_d.rd  = 1'b0;
    if (csn_q[1]) begin
      cnt_d = 5'h00;
      oe_d  = 1'b0;
    end else begin
      if (rise) begin
        sh_d  = {sh_q[14:0], mosi_q[1]};
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == 5'h07) begin
          req_d.addr = {sh_q[5:0], mosi_q[1]};
          req_d.rd   = ~sh_q[6];
        end
        if (cnt_q == 5'h0f) begin
          req_d.wr   = sh_q[14];
          req_d.data = {sh_q[6:0], mosi_q[1]};
        end
      end
      // Falling edge right after the load would drop the MSB
      if (fall && oe_q && (cnt_q > 5'h08)) begin
        tx_d = {tx_q[6:0], 1'b0};
      end
      if (req_q.rd) begin
        tx_d = rdata_in;
        oe_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sclk_q <= 3'h0;
      csn_q  <= 2'h3;
      mosi_q <= 2'h0;
      cnt_q  <= 5'h00;
      sh_q   <= 16'h0000;
      tx_q   <= 8'h00;
      oe_q   <= 1'b0;
      req_q  <= '0;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk_in};
      csn_q  <= {csn_q[0], spi_cs_n_in};
      mosi_q <= {mosi_q[0], mosi_in};
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      tx_q   <= tx_d;
      oe_q   <= oe_d;
      req_q  <= req_d;
    end
  end

endmodule

// File: testbench/vpo_host_model.sv
// Host model that drives serial register frames and collects the answer
`timescale 1ns/1ps
module vpo_host_model (
  // Clock
  input  wire logic clk_sys_in,
  // Link pins
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  // 80 ns half period of the link clock
  localparam int HALF = 20;

  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  task automatic pause(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  // One frame: rw bit, address, data, MSB first; link clock idles low
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [15:0] frame;
    frame = {wr, addr, wd};
    rd = 8'h00;
    @(posedge clk_sys_in);
    cs_n_out <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_out <= frame[i];
      pause(HALF);
      sclk_out <= 1'b1;
      rd[i % 8] = (i < 8) ? miso_in : rd[i % 8];
      pause(HALF);
      sclk_out <= 1'b0;
    end
    pause(HALF);
    cs_n_out <= 1'b1;
    // Released data line shows the inverse of its last bit
    mosi_out <= ~frame[0];
    pause(HALF);
  endtask
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the voltage path output and sequencing block
`timescale 1ns/1ps
`include "vpo_params.svh"
module testbench
  import vpo_pkg::*;
();
  localparam int INIT  = 800;
  localparam int STAB  = 1000;
  localparam int CONV  = 4000;
  localparam int SETL  = 500;
  localparam int SBC   = 300;
  localparam int STBY  = 7000;
  localparam int SBT   = STBY + SETL + 3 * SBC;
  localparam int LIMIT = 90000;

  logic       clk;
  logic       rst;
  logic       test_lock;
  logic       init_seen;
  logic       miso_w;
  logic       sclk;
  logic       cs_n;
  logic       mosi;
  logic       miso;
  logic       miso_oe;
  logic       ma_en;
  logic       conv_run;
  logic       int_pin;
  logic [3:0] ma_depth;
  vpo_words_s words;
  int         error_cnt = 0;
  int         checks = 0;
  int         cyc = 0;
  logic [3:0] depths [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
  logic [6:0] ro_addr [4] = '{7'h19, 7'h1a, 7'h2c, 7'h60};

  vpo_voltage_path #(
    .INIT_CYC(32'(INIT)), .STAB_CYC(32'(STAB)), .CONV_CYC(32'(CONV)),
    .SETTLE_CYC(32'(SETL)), .SBCONV_CYC(32'(SBC)), .STBY_CYC(32'(STBY))
  ) uut (
    .clk_sys_in(clk), .reset_in(rst), .sclk_in(sclk), .spi_cs_n_in(cs_n),
    .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe), .words_in(words),
    .test_lock_in(test_lock), .ma_enable_out(ma_en), .ma_depth_out(ma_depth),
    .conv_run_out(conv_run), .int_out(int_pin)
  );

  // Undriven data line shows a pattern that changes every cycle
  assign miso_w = miso_oe ? miso : cyc[0];

  vpo_host_model host (
    .clk_sys_in(clk), .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso_w)
  );

  // ----------------------------------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      $display("Error %0t: timeout", $time);
      tally_and_finish();
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      init_seen <= 1'b0;
    end else if (int_pin === 1'b1) begin
      init_seen <= 1'b1;
    end
  end

  task automatic tally_and_finish();
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] want, input string what);
    checks++;
    if (got !== want) begin
      error_cnt++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, want);
    end
  endtask

  task automatic in_range(input int n, input int lo, input int hi);
    check(16'(n >= lo && n <= hi), 16'h1, "interval");
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    host.xfer(1'b1, a, d, unused);
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    host.xfer(1'b0, a, 8'($urandom), d);
  endtask

  task automatic wait_int(input int max, output int at);
    int n;
    n = 0;
    while (int_pin !== 1'b1 && n < max) begin
      @(posedge clk);
      n++;
    end
    at = cyc;
  endtask

  function automatic logic [15:0] pick(input logic [1:0] sel, input logic ma,
                                       input vpo_words_s w);
    case (sel)
      `VPO_SRC_FILT:   return ma ? w.avg : w.fir;
      `VPO_SRC_CIC2:   return w.cic2;
      `VPO_SRC_DECHOP: return w.dechop;
      default:         return w.cic1;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0]  v;
    logic [7:0]  s;
    logic [7:0]  f;
    logic [1:0]  sel;
    logic [15:0] want;
    int          at;
    int          tp;
    int          t0;
    rst = 1'b1;
    test_lock = 1'b0;
    words = '0;
    void'($urandom(99556));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    host.pause(INIT - 40);
    check(16'(init_seen), 16'h1, "init toggle");
    check(16'({ma_en, ma_depth}), 16'h0, "filter pins reset");
    host.pause(60);
    rd(`VPO_ADDR_DEC2, v);
    check(16'(v), 16'h04, "select reset");
    rd(`VPO_ADDR_FILT, v);
    check(16'(v), 16'h00, "filter reset");
    f = 8'h00;
    foreach (depths[i]) begin
      f = {1'($urandom) | 1'(i == 4), depths[i], 3'($urandom)};
      wr(`VPO_ADDR_FILT, f);
      check(16'({ma_en, ma_depth}), 16'(f[7:3]), "filter pins");
      rd(`VPO_ADDR_FILT, v);
      check(16'(v), 16'(f & 8'hf8), "filter read");
    end
    foreach (ro_addr[i]) begin
      test_lock <= 1'($urandom);
      wr(ro_addr[i], 8'hff);
      rd(ro_addr[i], v);
      check(16'(v), 16'h00, "read-only span");
    end
    words <= 80'({$urandom, $urandom, $urandom});
    wr(`VPO_ADDR_MODE, `VPO_CMD_START);
    t0 = cyc;
    tp = t0;
    for (int i = 0; i < 5; i++) begin
      sel = 2'(i);
      wr(`VPO_ADDR_DEC2, {4'h0, sel, 2'h0});
      if (i == 4) begin
        f = f ^ 8'h80;
        wr(`VPO_ADDR_FILT, f);
      end
      wait_int(STAB + CONV + 100, at);
      if (i == 0) begin
        in_range(at - t0, STAB + CONV - 60, STAB + CONV);
      end else begin
        in_range(at - tp, CONV - 1, CONV + 1);
      end
      tp = at;
      want = pick(sel, f[7], words);
      words <= 80'({$urandom, $urandom, $urandom});
      rd(`VPO_ADDR_DATA_HI, v);
      rd(`VPO_ADDR_DATA_LO, s);
      check({v, s}, want, "data word");
      check(16'(int_pin), 16'h1, "status held");
      rd(`VPO_ADDR_STATUS, v);
      check(16'(v), 16'h01, "status");
      check(16'(int_pin), 16'h0, "status cleared");
    end
    wr(`VPO_ADDR_DEC2, {4'h1, sel, 2'h0});
    host.pause(CONV);
    check(16'(int_pin), 16'h0, "masked");
    wr(`VPO_ADDR_MODE, `VPO_CMD_STOP);
    check(16'(conv_run), 16'h0, "stopped");
    rd(`VPO_ADDR_STATUS, v);
    check(16'(v), 16'h01, "masked status");
    host.pause(2 * CONV);
    rd(`VPO_ADDR_STATUS, v);
    check(16'(v), 16'h00, "halted capture");
    wr(`VPO_ADDR_DEC2, {4'h0, sel, 2'h0});
    wr(`VPO_ADDR_MODE, `VPO_CMD_STBY);
    t0 = cyc;
    check(16'(conv_run), 16'h0, "standby idle");
    wait_int(SBT + 100, at);
    in_range(at - t0, SBT - 60, SBT);
    host.pause(4);
    check(16'(conv_run), 16'h0, "halt after result");
    rd(`VPO_ADDR_STATUS, v);
    check(16'(v), 16'h01, "standby status");
    tp = at;
    wait_int(STBY + 100, at);
    in_range(at - tp, STBY - 1, STBY + 1);
    tally_and_finish();
  end
endmodule
